// [core/crc_scan_pkg.sv]
/*
 * constants, field positions, reset values and state types for the flash
 * checksum scanner and its register slave.
 * assumes: one 100 MHz clock; the register window is reached over axi4-lite,
 * each register in the low byte of its own aligned word.
 */
// Functional notes
// RL1: setup register ignores writes while busy or after a failure nmi fired.
// RL2: access mode 0x0 is priority: one check, cpu halted until done.
// RL3: after a startup scan the mode field reads non-zero; software rewrites 0x0.
// RL4: section select 0 whole, 1 boot plus application, 2 boot, 3 reserved.
// RL5: after a startup scan the section field reads back the configured region.
// RL6: progress flags are read only, writes ignored, reset value 0x02.
// RL7: pass flag is one after reset and cleared when the scanner is enabled.
// RL8: pass flag reads zero for the whole time a check is busy.
// RL9: pass flag reads one only when the last finished check matched.
// RL10: busy flag is one exactly while a check is in progress.
// RL11: while busy, protected control fields refuse writes.
// RL12: software treats a continuous scan as passing until failure or stop.
// RL13: in priority mode one 16-bit flash word is fetched every third cycle.
// RL14: the check begins three cycles after enable is written, cpu keeps running.
// RL15: a mismatch clears pass and, if enabled, raises an nmi held until reset.
// RL16: a reserved mode or section code performs no check at all.
package crc_scan_pkg;

   // register indices; byte address is four times the index
   localparam logic [2:0] IDX_CTRL     = 3'h0;
   localparam logic [2:0] IDX_SETUP    = 3'h1;
   localparam logic [2:0] IDX_FLAGS    = 3'h2;
   localparam logic [2:0] IDX_IRQ_STAT = 3'h3;
   localparam logic [2:0] IDX_IRQ_MASK = 3'h4;

   // field positions
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_FAILURE_INTERRUPT_ENABLE_BIT  = 1;
   localparam int CTRL_RESET_BIT  = 7;
   localparam int MODE_LSB        = 4;
   localparam int SRC_LSB         = 0;
   localparam int FLAG_BUSY_BIT   = 0;
   localparam int FLAG_PASS_BIT   = 1;
   localparam int IRQ_DONE_BIT    = 0;
   localparam int IRQ_FAIL_BIT    = 1;

   // reset values
   localparam logic [7:0] SETUP_RESET = 8'h00;
   localparam logic [7:0] FLAGS_RESET = 8'h02;

   // field codes
   localparam logic [1:0] MODE_PRIORITY = 2'h0;
   localparam logic [1:0] MODE_STARTUP  = 2'h1;
   localparam logic [1:0] SRC_WHOLE     = 2'h0;
   localparam logic [1:0] SRC_BOOT_APP  = 2'h1;
   localparam logic [1:0] SRC_BOOT      = 2'h2;
   localparam logic [1:0] SRC_RESERVED  = 2'h3;

   // cycle counts
   localparam logic [1:0] START_DELAY_CYC  = 2'h3;
   localparam logic [1:0] FETCH_PERIOD_CYC = 2'h3;
   localparam logic [1:0] PHASE_ISSUE      = 2'h0;
   localparam logic [1:0] PHASE_TAKE       = 2'h1;

   // flash section unit: one fuse step is 256 bytes, 128 words
   localparam int WORDS_PER_FUSE_UNIT = 128;

   // checksum
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'h1021;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_SCAN} scan_state_e;

endpackage

// [core/crc16_word_step.sv]
/*
 * one 16-bit word folded into a crc16, msb first, combinational.
 * assumes: caller registers the result.
 */
`timescale 1ns/1ps
module crc16_word_step #(
   parameter logic [15:0] POLY = crc_scan_pkg::CRC_POLY
) (
   input  wire logic [15:0] crc_in,
   input  wire logic [15:0] word,
   output logic      [15:0] crc_out
);
   import crc_scan_pkg::*;

   // bitwise shift register, unrolled by the loop
   always_comb begin
      logic [15:0] c;
      c = crc_in;
      for (int i = 15; i >= 0; i--) begin
         if (c[15] ^ word[i]) begin
            c = {c[14:0], 1'b0} ^ POLY;
         end else begin
            c = {c[14:0], 1'b0};
         end
      end
      crc_out = c;
   end

endmodule

// [core/flash_checksum_scanner.sv]
/*
 * flash checksum scanner: control, setup and progress flag registers on an
 * axi4-lite slave, a priority-mode flash walker and an interrupt block.
 * assumes: flash answers a read one cycle after flash_rd; the checksum word
 * sits in the last word of the section; fuse inputs are stable.
 */
`timescale 1ns/1ps
module flash_checksum_scanner #(
   parameter int AXI_AW      = 8,
   parameter int FLASH_WORDS = 2048,
   parameter int FLASH_AW    = $clog2(FLASH_WORDS)
) (
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire logic [AXI_AW-1:0]        awaddr,
   input  wire logic                     awvalid,
   output logic                          awready,
   input  wire logic [31:0]              wdata,
   input  wire logic [3:0]               wstrb,
   input  wire logic                     wvalid,
   output logic                          wready,
   output logic [1:0]                    bresp,
   output logic                          bvalid,
   input  wire logic                     bready,
   input  wire logic [AXI_AW-1:0]        araddr,
   input  wire logic                     arvalid,
   output logic                          arready,
   output logic [31:0]                   rdata,
   output logic [1:0]                    rresp,
   output logic                          rvalid,
   input  wire logic                     rready,
   output logic                          flash_rd,
   output logic [FLASH_AW-1:0]           flash_addr,
   input  wire logic [15:0]              flash_rdata,
   input  wire logic [7:0]               boot_end_fuse,
   input  wire logic [7:0]               app_end_fuse,
   input  wire logic                     scan_at_reset,
   input  wire logic [1:0]               reset_section_select,
   output logic                          cpu_stall,
   output logic                          nmi,
   output logic                          irq
);
   import crc_scan_pkg::*;

   typedef struct packed {
      logic                awready;
      logic                wready;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                arready;
      logic                rvalid;
      logic [1:0]          rresp;
      logic [7:0]          rdata;
      logic                aw_held;
      logic                aw_ok;
      logic [2:0]          aw_idx;
      logic                w_held;
      logic [7:0]          wbyte;
      logic                wlane;
      logic                enable;
      logic                failure_interrupt_enable;
      logic [1:0]          mode;
      logic [1:0]          section_select;
      logic                busy;
      logic                pass;
      logic                nmi;
      logic                rst_pend;
      logic                strap_pend;
      logic                from_strap;
      scan_state_e         state;
      logic [1:0]          arm_cnt;
      logic [1:0]          phase;
      logic [FLASH_AW-1:0] waddr;
      logic [FLASH_AW-1:0] last;
      logic [15:0]         crc;
      logic                flash_rd;
      logic [1:0]          irq_stat;
      logic [1:0]          irq_mask;
      logic                irq;
   } scan_s;

   scan_s       st;
   scan_s       next_st;
   logic [15:0] crc_next;
   logic        wr_do;
   logic        start_req;
   logic        setup_wr;
   logic        fail_evt;
   logic        done_evt;
   logic        cfg_ok;

   // aligned word decode: index in bits 4:2, nothing mapped above
   function automatic logic idx_ok(input logic [AXI_AW-1:0] a);
      return (a[AXI_AW-1:5] == '0) && (a[4:2] <= IDX_IRQ_MASK) && (a[1:0] == 2'h0);
   endfunction

   // last word of the chosen section; its content is the stored checksum
   function automatic logic [FLASH_AW-1:0] section_last(input logic [1:0] s);
      logic [31:0] w;
      w = 32'(FLASH_WORDS);
      if (s == SRC_BOOT_APP) begin
         w = 32'(app_end_fuse) * 32'(WORDS_PER_FUSE_UNIT);
      end else if (s == SRC_BOOT) begin
         w = 32'(boot_end_fuse) * 32'(WORDS_PER_FUSE_UNIT);
      end
      return FLASH_AW'(w - 32'h1);
   endfunction

   crc16_word_step #(
      .POLY    (CRC_POLY)
   ) i_crc16_word_step (
      .crc_in  (st.crc),
      .word    (flash_rdata),
      .crc_out (crc_next)
   );

   // reserved mode or section gives no check; a startup scan bypasses mode
   assign cfg_ok = (st.mode == MODE_PRIORITY || st.from_strap)
                   && st.section_select != SRC_RESERVED; // RL2 RL4 RL16

   // next state of the whole block
   always_comb begin
      next_st   = st;
      fail_evt  = 1'b0;
      done_evt  = 1'b0;
      start_req = 1'b0;
      setup_wr  = 1'b0;
      wr_do     = st.aw_held && st.w_held && !st.bvalid;

      // read channel: answer one cycle after the address is taken
      if (st.rvalid && rready) begin
         next_st.rvalid = 1'b0;
      end
      if (arvalid && st.arready) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = idx_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
         next_st.rdata  = 8'h00;
         if (idx_ok(araddr)) begin
            unique case (araddr[4:2])
               IDX_CTRL:     next_st.rdata = {6'h00, st.failure_interrupt_enable, st.enable};
               IDX_SETUP:    next_st.rdata = {2'h0, st.mode, 2'h0, st.section_select};
               IDX_FLAGS:    next_st.rdata = {6'h00, st.pass, st.busy}; // RL10
               IDX_IRQ_STAT: next_st.rdata = {6'h00, st.irq_stat};
               IDX_IRQ_MASK: next_st.rdata = {6'h00, st.irq_mask};
               default:      next_st.rdata = 8'h00;
            endcase
         end
      end

      // write channels: address and data taken in either order
      if (awvalid && st.awready) begin
         next_st.aw_held = 1'b1;
         next_st.aw_ok   = idx_ok(awaddr);
         next_st.aw_idx  = awaddr[4:2];
      end
      if (wvalid && st.wready) begin
         next_st.w_held = 1'b1;
         next_st.wbyte  = wdata[7:0];
         next_st.wlane  = wstrb[0];
      end
      if (st.bvalid && bready) begin
         next_st.bvalid = 1'b0;
      end

      // scan sequencer
      unique case (st.state)
         ST_IDLE: begin
         end
         ST_ARM: begin
            if (st.arm_cnt != 2'h0) begin
               next_st.arm_cnt = st.arm_cnt - 2'h1;
            end else if (cfg_ok) begin
               next_st.state    = ST_SCAN;
               next_st.busy     = 1'b1; // RL10
               next_st.phase    = PHASE_ISSUE;
               next_st.waddr    = '0;
               next_st.last     = section_last(st.section_select); // RL4
               next_st.crc      = CRC_INIT;
            end else begin
               next_st.state = ST_IDLE; // RL16
            end
         end
         ST_SCAN: begin
            next_st.phase = (st.phase == FETCH_PERIOD_CYC - 2'h1) ? PHASE_ISSUE
                            : st.phase + 2'h1; // RL13
            if (st.phase == PHASE_TAKE) begin
               if (st.waddr == st.last) begin
                  next_st.state      = ST_IDLE;
                  next_st.busy       = 1'b0;
                  next_st.from_strap = 1'b0;
                  done_evt           = 1'b1;
                  next_st.pass       = (flash_rdata == st.crc); // RL9
                  if (flash_rdata != st.crc) begin
                     fail_evt    = 1'b1; // RL15
                     next_st.nmi = st.nmi || st.failure_interrupt_enable; // RL15
                  end
               end else begin
                  next_st.crc   = crc_next;
                  next_st.waddr = st.waddr + 1'b1;
               end
            end
         end
      endcase

      // startup scan: strap caught on the first edge after release
      if (st.strap_pend) begin
         next_st.strap_pend = 1'b0;
         if (scan_at_reset) begin
            next_st.enable         = 1'b1;
            next_st.mode           = MODE_STARTUP; // RL3
            next_st.section_select = reset_section_select; // RL5
            next_st.pass           = 1'b0;
            next_st.from_strap     = 1'b1;
            next_st.state          = ST_ARM;
            next_st.arm_cnt        = 2'h0;
         end
      end

      // reset strobe takes effect one cycle after the write
      if (st.rst_pend) begin
         next_st.rst_pend       = 1'b0;
         next_st.enable         = 1'b0;
         next_st.mode           = 2'h0;
         next_st.section_select = 2'h0;
         next_st.busy           = 1'b0;
         next_st.pass           = 1'b0;
         next_st.state          = ST_IDLE;
         next_st.from_strap     = 1'b0;
      end

      // register write, answered the cycle after both halves are held
      if (wr_do) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = st.aw_ok ? RESP_OKAY : RESP_SLVERR;
         if (st.aw_ok && st.wlane) begin
            unique case (st.aw_idx)
               IDX_CTRL: begin
                  // once the nmi fired the control register takes no writes; irq status and mask still do
                  if (!st.nmi) begin
                     next_st.enable = st.wbyte[CTRL_ENABLE_BIT];
                     if (st.wbyte[CTRL_FAILURE_INTERRUPT_ENABLE_BIT] && !st.busy) begin
                        next_st.failure_interrupt_enable = 1'b1; // RL11
                     end
                     if (st.wbyte[CTRL_RESET_BIT] && (!st.failure_interrupt_enable || !st.busy)) begin
                        next_st.rst_pend = 1'b1;
                     end
                     if (st.wbyte[CTRL_ENABLE_BIT] && st.state == ST_IDLE) begin
                        start_req       = 1'b1;
                        next_st.pass    = 1'b0; // RL7
                        next_st.state   = ST_ARM;
                        next_st.arm_cnt = START_DELAY_CYC - 2'h1; // RL14
                     end
                  end
               end
               IDX_SETUP: begin
                  setup_wr = 1'b1;
                  if (!st.busy && !st.nmi) begin // RL1 RL11
                     next_st.mode           = st.wbyte[MODE_LSB +: 2]; // RL2 RL3
                     next_st.section_select = st.wbyte[SRC_LSB +: 2]; // RL4
                  end
               end
               IDX_FLAGS: begin
               end
               IDX_IRQ_STAT: begin
                  next_st.irq_stat = st.irq_stat & ~st.wbyte[1:0];
               end
               IDX_IRQ_MASK: begin
                  next_st.irq_mask = st.wbyte[1:0];
               end
               default: begin
               end
            endcase
         end
      end

      // sticky events, set wins over a clear in the same cycle
      next_st.irq_stat[IRQ_DONE_BIT] = next_st.irq_stat[IRQ_DONE_BIT] | done_evt;
      next_st.irq_stat[IRQ_FAIL_BIT] = next_st.irq_stat[IRQ_FAIL_BIT] | fail_evt;
      next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
      next_st.flash_rd = (next_st.state == ST_SCAN) && (next_st.phase == PHASE_ISSUE);
      next_st.awready  = !next_st.aw_held && !next_st.bvalid;
      next_st.wready   = !next_st.w_held && !next_st.bvalid;
      next_st.arready  = !next_st.rvalid;
      // pass can never show while busy, whatever path set it
      if (next_st.busy) begin
         next_st.pass = 1'b0; // RL8
      end

      // synchronous reset: flags come up as 0x02, setup as 0x00
      if (!aresetn) begin
         next_st                = '0;
         next_st.pass           = FLAGS_RESET[FLAG_PASS_BIT]; // RL6 RL7
         next_st.busy           = FLAGS_RESET[FLAG_BUSY_BIT];
         next_st.mode           = SETUP_RESET[MODE_LSB +: 2];
         next_st.section_select = SETUP_RESET[SRC_LSB +: 2];
         next_st.state          = ST_IDLE;
         next_st.strap_pend     = 1'b1;
      end
   end

   // the single state register
   always_ff @(posedge aclk) begin
      st <= next_st;
   end

   // every output straight from the state register
   assign awready    = st.awready;
   assign wready     = st.wready;
   assign bvalid     = st.bvalid;
   assign bresp      = st.bresp;
   assign arready    = st.arready;
   assign rvalid     = st.rvalid;
   assign rresp      = st.rresp;
   assign rdata      = {24'h000000, st.rdata};
   assign flash_rd   = st.flash_rd;
   assign flash_addr = st.waddr;
   assign cpu_stall  = st.busy; // RL2
   assign nmi        = st.nmi;
   assign irq        = st.irq;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_setup_locked;
      wr_do && setup_wr && (st.busy || st.nmi) |=> $stable({st.mode, st.section_select});
   endproperty
   a_setup_locked: assert property (p_setup_locked) else $error("setup changed while locked"); // RL1

   property p_busy_refuses_failure_interrupt_enable;
      st.busy && !st.failure_interrupt_enable |-> ##1 (!st.failure_interrupt_enable || !$past(st.busy));
   endproperty
   a_busy_refuses_failure_interrupt_enable: assert property (p_busy_refuses_failure_interrupt_enable) else $error("failure_interrupt_enable set while busy"); // RL11

   property p_reset_flags;
      $rose(aresetn) |-> st.pass && !st.busy && st.mode == 2'h0;
   endproperty
   a_reset_flags: assert property (@(posedge aclk) p_reset_flags) else $error("bad flags after reset"); // RL6

   property p_enable_clears_pass;
      start_req |=> !st.pass;
   endproperty
   a_enable_clears_pass: assert property (p_enable_clears_pass) else $error("pass kept after enable"); // RL7

   property p_busy_no_pass;
      st.busy |-> !st.pass;
   endproperty
   a_busy_no_pass: assert property (p_busy_no_pass) else $error("pass shown while busy"); // RL8

   property p_pass_from_check;
      $rose(st.pass) |-> !$past(st.busy) || $past(flash_rdata) == $past(st.crc);
   endproperty
   a_pass_from_check: assert property (p_pass_from_check) else $error("pass after failed check"); // RL9

   property p_fetch_period;
      st.flash_rd |=> !st.flash_rd ##1 !st.flash_rd ##1 (st.flash_rd || !st.busy || st.rst_pend);
   endproperty
   a_fetch_period: assert property (p_fetch_period) else $error("fetch spacing not three"); // RL13

   property p_start_delay;
      start_req && cfg_ok && !st.rst_pend |=> !st.busy [*3] ##1 (st.busy || !cfg_ok);
   endproperty
   a_start_delay: assert property (p_start_delay) else $error("check did not start after three"); // RL14

   property p_fail_nmi;
      fail_evt && st.failure_interrupt_enable |=> st.nmi && !st.pass ##1 st.nmi;
   endproperty
   a_fail_nmi: assert property (p_fail_nmi) else $error("failure did not hold nmi"); // RL15

   property p_reserved_nocheck;
      st.state == ST_ARM && st.arm_cnt == 2'h0 && !cfg_ok |=> !st.busy && st.state == ST_IDLE;
   endproperty
   a_reserved_nocheck: assert property (p_reserved_nocheck) else $error("reserved code scanned"); // RL16

   property p_strap_fields;
      st.strap_pend && scan_at_reset |=> st.mode != 2'h0 && st.enable;
   endproperty
   a_strap_fields: assert property (p_strap_fields) else $error("startup fields wrong"); // RL3

   c_pass:     cover property (done_evt && !fail_evt);
   c_fail_nmi: cover property (fail_evt && st.failure_interrupt_enable);
   c_reserved: cover property (st.state == ST_ARM && st.arm_cnt == 2'h0 && !cfg_ok);
   c_strap:    cover property (st.strap_pend && scan_at_reset);

endmodule

// [test/flash_model.sv]
/*
 * behavioural flash array answering word reads of the checksum scanner.
 * assumes: a one-cycle read pulse; the word is due in the following cycle.
 */
`timescale 1ns/1ps
module flash_model #(
   parameter int WORDS = 256,
   parameter int AW    = 8
) (
   input  wire logic          aclk,
   input  wire logic          rd,
   input  wire logic [AW-1:0] addr,
   output logic      [15:0]   rdata
);
   logic [15:0] mem [WORDS];

   // non-trivial pattern; the bench seals the checksum word itself
   initial begin
      for (int i = 0; i < WORDS; i++) begin
         mem[i] = 16'(i * 16'h0b05 + 16'h1234);
      end
      rdata = 16'h0000;
   end

   // word valid for one cycle only; toggling otherwise so stale data never matches
   always @(posedge aclk) begin
      if (rd === 1'b1) begin
         rdata <= mem[addr];
      end else begin
         rdata <= ~rdata;
      end
   end
endmodule

// [test/flash_checksum_scanner_tb.sv]
/*
 * self-checking bench of the flash checksum scanner: axi4-lite accesses,
 * section walks, reserved codes, failure interrupt and startup scan.
 * assumes: flash_model on the far side; flash shrunk to 256 words.
 */
`timescale 1ns/1ps
module flash_checksum_scanner_tb;
   import crc_scan_pkg::*;

   localparam int         FW      = 256;
   localparam logic [7:0] A_CTRL  = {3'h0, IDX_CTRL, 2'h0};
   localparam logic [7:0] A_SETUP = {3'h0, IDX_SETUP, 2'h0};
   localparam logic [7:0] A_FLAGS = {3'h0, IDX_FLAGS, 2'h0};
   localparam logic [7:0] A_STAT  = {3'h0, IDX_IRQ_STAT, 2'h0};
   localparam logic [7:0] A_MASK  = {3'h0, IDX_IRQ_MASK, 2'h0};

   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, flash_rd, cpu_stall, nmi, irq;
   logic        scan_at_reset;
   logic [7:0]  awaddr, araddr, boot_end_fuse, app_end_fuse, flash_addr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, reset_section_select, wresp, rresp_seen;
   logic [15:0] flash_rdata;
   int          mismatches, checked, nrd, gap, badgap;

   flash_checksum_scanner #(.FLASH_WORDS(FW)) i_flash_checksum_scanner (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .flash_rd, .flash_addr, .flash_rdata,
      .boot_end_fuse, .app_end_fuse, .scan_at_reset, .reset_section_select,
      .cpu_stall, .nmi, .irq
   );

   flash_model #(.WORDS(FW), .AW(8)) i_flash_model (
      .aclk, .rd(flash_rd), .addr(flash_addr), .rdata(flash_rdata)
   );

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // count fetches; gap is zero until a walk's first fetch, which has no peer
   always @(posedge aclk) begin
      gap <= (cpu_stall === 1'b1) ? gap + 1 : 0;
      if (flash_rd === 1'b1) begin
         nrd <= nrd + 1;
         gap <= 1;
         if (cpu_stall === 1'b1 && gap != 0 && gap != 3) badgap <= badgap + 1;
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // bready and rready stay high throughout, so no release race between calls
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 50);
      wresp = bresp;
      chk("write answer", 16'h0, 16'(n >= 50));
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      d = rdata[7:0];
      rresp_seen = rresp;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
      logic [7:0] d;
      rd(a, d);
      chk(what, exp, d);
   endtask

   task automatic wait_idle;
      int n;
      n = 0;
      while (cpu_stall !== 1'b0 && n < 3000) begin
         @(posedge aclk);
         n++;
      end
      chk("scan end", 16'h0, 16'(n >= 3000));
   endtask

   // checksum worked out here, msb first, into the last word of the section
   task automatic seal(input int last, input bit good);
      logic [15:0] c;
      c = CRC_INIT;
      for (int i = 0; i < last; i++) begin
         c = c ^ i_flash_model.mem[i];
         for (int b = 0; b < 16; b++) c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      i_flash_model.mem[last] = good ? c : ~c;
   endtask

   task automatic do_reset;
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask

   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge aclk);
      mismatches++;
      tally_and_finish;
   end

   initial begin
      logic [7:0] d;
      static logic [1:0] srcs [3] = '{SRC_BOOT, SRC_BOOT_APP, SRC_WHOLE};
      static logic [7:0] rsv [4] = '{8'h10, 8'h20, 8'h30, 8'h03};
      int         last, n0;
      {awvalid, wvalid, arvalid, scan_at_reset, aresetn} = '0;
      {awaddr, araddr, wdata, wstrb, reset_section_select} = '0;
      {bready, rready} = 2'b11;
      boot_end_fuse = 8'h01;
      app_end_fuse = 8'h02;
      {mismatches, checked, nrd, gap, badgap} = '0;
      do_reset;
      // reset values, read-only flags, unmapped place
      rchk(A_SETUP, SETUP_RESET, "setup reset");
      rchk(A_FLAGS, FLAGS_RESET, "flags reset");
      wr(A_FLAGS, 8'hfd);
      rchk(A_FLAGS, FLAGS_RESET, "flags after write");
      wr(8'h14, 8'h01);
      chk("unmapped write", RESP_SLVERR, wresp);
      rd(8'h14, d);
      chk("unmapped read", RESP_SLVERR, rresp_seen);
      $display("test registers done");
      // good walk of each section with setup writes tried mid-walk
      foreach (srcs[k]) begin
         last = (k == 0) ? 127 : FW - 1;
         seal(last, 1'b1);
         n0 = nrd;
         wr(A_SETUP, {6'h0, srcs[k]});
         wr(A_CTRL, 8'h01);
         @(posedge aclk);
         #1 chk("stall before start", 16'h0, cpu_stall);
         @(posedge aclk);
         #1 chk("stall at start", 16'h1, cpu_stall);
         rchk(A_FLAGS, 8'h01, "flags busy");
         wr(A_SETUP, 8'h03);
         wait_idle;
         rchk(A_SETUP, {6'h0, srcs[k]}, "setup kept");
         rchk(A_FLAGS, 8'h02, "flags pass");
         chk("flash reads", 16'(last + 1), 16'(nrd - n0));
      end
      chk("fetch spacing", 16'h0, 16'(badgap));
      $display("test sections done");
      // done event: masked, unmasked, cleared by writing one
      rchk(A_STAT, 8'h01, "irq status done");
      #1 chk("irq masked", 16'h0, irq);
      wr(A_MASK, 8'h01);
      @(posedge aclk);
      #1 chk("irq unmasked", 16'h1, irq);
      wr(A_STAT, 8'h01);
      @(posedge aclk);
      #1 chk("irq cleared", 16'h0, irq);
      $display("test interrupt done");
      // reserved codes: enable clears pass yet no walk starts
      foreach (rsv[k]) begin
         n0 = nrd;
         wr(A_SETUP, rsv[k]);
         wr(A_CTRL, 8'h01);
         repeat (8) @(posedge aclk);
         #1 chk("stall reserved", 16'h0, cpu_stall);
         chk("reads reserved", 16'h0, 16'(nrd - n0));
         rchk(A_FLAGS, 8'h00, "flags reserved");
      end
      // reset strobe while idle clears the setup left by the last reserved try
      wr(A_CTRL, 8'h80);
      rchk(A_SETUP, 8'h00, "setup after strobe");
      $display("test reserved done");
      // mismatch with failure interrupt on; later writes refused
      seal(FW - 1, 1'b0);
      wr(A_SETUP, 8'h00);
      wr(A_CTRL, 8'h03);
      repeat (4) @(posedge aclk);
      wait_idle;
      rchk(A_FLAGS, 8'h00, "flags failed");
      rchk(A_STAT, 8'h03, "irq status fail");
      #1 chk("nmi raised", 16'h1, nmi);
      wr(A_SETUP, 8'h02);
      rchk(A_SETUP, 8'h00, "setup after nmi");
      wr(A_CTRL, 8'h80);
      @(posedge aclk);
      #1 chk("nmi held", 16'h1, nmi);
      $display("test failure done");
      // startup scan of the boot section requested by the strap
      seal(127, 1'b1);
      scan_at_reset <= 1'b1;
      reset_section_select <= SRC_BOOT;
      do_reset;
      repeat (4) @(posedge aclk);
      #1 chk("startup stall", 16'h1, cpu_stall);
      wait_idle;
      #1 chk("nmi after reset", 16'h0, nmi);
      rd(A_SETUP, d);
      chk("startup mode", 16'h1, 16'(d[5:4] != MODE_PRIORITY));
      chk("startup section", SRC_BOOT, d[1:0]);
      rchk(A_FLAGS, 8'h02, "startup pass");
      wr(A_SETUP, 8'h02);
      rchk(A_SETUP, 8'h02, "mode rewritten");
      $display("test startup done");
      tally_and_finish;
   end
endmodule
